// >>> dv/zero_turnaround_sync_sram_port_tb_top.sv
// Purpose: Self-checking bench for the zero-turnaround SRAM port.
// Assumes: One 125 MHz clock; the master model drives synchronous pins.
// Notes:   Memory starts unknown, so every read follows a full write.
`include "zts_consts.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////
module zero_turnaround_sync_sram_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] sel_ok  = 3'h2;
  localparam logic [2:0] sel_off = 3'h6;
  logic                i_mclk        = 1'b0;
  logic                i_rst         = 1'b1;
  logic                i_out_drive_n = 1'b0;
  logic                i_sleep_req   = 1'b0;
  logic                i_burst_order = 1'b0;
  logic                hold_n;
  logic                ld_n;
  logic [2:0]          sel;
  logic                wr_n;
  zts_pkg::zts_lanes_t lanes_n;
  zts_pkg::zts_addr_t  addr;
  zts_pkg::zts_word_t  dq_in;
  zts_pkg::zts_word_t  dq_out;
  logic                dq_oe;
  int                  miscompares  = 0;
  int                  total_checks = 0;
  int                  cycles       = 0;

  always #4 i_mclk = ~i_mclk;

  zts_master_model m (.i_mclk(i_mclk), .o_cycle_hold_n(hold_n), .o_advance_load_n(ld_n), .o_select(sel),
                      .o_write_n(wr_n), .o_lane_write_n(lanes_n), .o_addr(addr), .o_dq(dq_in));

  zts_sram_port dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cycle_hold_n(hold_n), .i_advance_load_n(ld_n),
                     .i_select_a_n(sel[2]), .i_select_b(sel[1]), .i_select_c_n(sel[0]), .i_write_n(wr_n),
                     .i_lane_write_n(lanes_n), .i_addr(addr), .i_out_drive_n(i_out_drive_n),
                     .i_sleep_req(i_sleep_req), .i_burst_order(i_burst_order), .i_dq(dq_in),
                     .o_dq(dq_out), .o_dq_oe(dq_oe));

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Tests take well under 200 cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input zts_pkg::zts_word_t seen, input zts_pkg::zts_word_t exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, msg, seen, exp);
    end
  endtask : check

  // Data is judged only while the bus is driven
  task automatic see(input logic oe, input zts_pkg::zts_word_t exp, input string msg);
    #1;
    check({35'h0, dq_oe}, {35'h0, oe}, msg);
    if (oe) check(dq_out, exp, msg);
  endtask : see

  function automatic zts_pkg::zts_word_t mrg(input zts_pkg::zts_word_t o, input zts_pkg::zts_word_t n,
                                             input zts_pkg::zts_lanes_t ln);
    mrg = o;
    for (int i = 0; i < `ZTS_LANES; i++) begin
      if (!ln[i]) mrg[i*`ZTS_LANE_W +: `ZTS_LANE_W] = n[i*`ZTS_LANE_W +: `ZTS_LANE_W];
    end
  endfunction : mrg

  ////////////////////////////////////////////////////////////////////////
  task automatic t_pingpong();
    m.beat(0, 0, sel_ok, 0, 4'h0, 18'h00010, 0, 0);
    m.beat(0, 0, sel_ok, 0, 4'h0, 18'h00020, 1, 36'h123456789);
    see(0, 0, "write release");
    m.beat(0, 0, sel_ok, 1, 4'hF, 18'h00010, 1, 36'hFEDCBA987);
    see(0, 0, "write release");
    m.beat(0, 0, sel_ok, 0, 4'h5, 18'h00020, 0, 0);
    see(1, 36'h123456789, "read after write");
    m.beat(0, 0, sel_ok, 1, 4'hF, 18'h00020, 1, 36'h0AAAAAAAA);
    see(0, 0, "read to write");
    m.beat(0, 0, sel_off, 1, 4'hF, 18'h0, 0, 0);
    see(1, mrg(36'hFEDCBA987, 36'h0AAAAAAAA, 4'h5), "lane write");
  endtask : t_pingpong

  task automatic t_burst(input logic ord);
    zts_pkg::zts_beat_t low;
    m.beat(0, 0, sel_ok, 0, 4'h0, 18'h00100, 0, 0);
    i_burst_order <= ord;
    for (int n = 0; n < 3; n++) m.beat(0, 1, sel_ok, 1, 4'h0, 18'h0, 1, 36'h0C0DE0000 + 36'(n));
    m.beat(0, 0, sel_off, 1, 4'hF, 18'h0, 1, 36'h0C0DE0003);
    m.beat(0, 0, sel_ok, 1, 4'hF, 18'h00102, 0, 0);
    for (int n = 0; n < 4; n++) begin
      if (n < 3) m.beat(0, 1, sel_ok, 1, 4'hF, 18'h0, 0, 0);
      else m.beat(0, 0, sel_off, 1, 4'hF, 18'h0, 0, 0);
      low = ord ? (2'h2 ^ 2'(n)) : (2'h2 + 2'(n));
      see(1, 36'h0C0DE0000 + 36'(low), "burst beat");
    end
    m.beat(0, 1, sel_ok, 1, 4'hF, 18'h0, 0, 0);
    see(0, 0, "deselect ends burst");
    m.beat(0, 0, sel_off, 1, 4'hF, 18'h0, 0, 0);
    see(0, 0, "advance idles");
  endtask : t_burst

  task automatic t_hold();
    m.beat(0, 0, sel_ok, 1, 4'hF, 18'h00010, 0, 0);
    m.beat(1, 0, sel_ok, 0, 4'h0, 18'h00020, 0, 0);
    see(1, 36'h123456789, "read");
    m.beat(1, 0, sel_ok, 0, 4'h0, 18'h00020, 0, 0);
    see(1, 36'h123456789, "held edge");
    m.beat(1, 0, sel_ok, 0, 4'h0, 18'h00020, 0, 0);
    i_out_drive_n <= 1'b1;
    see(0, 0, "drive off");
    m.beat(1, 0, sel_ok, 0, 4'h0, 18'h00030, 0, 0);
    i_out_drive_n <= 1'b0;
    i_sleep_req   <= 1'b1;
    see(0, 0, "sleep");
    m.beat(0, 0, sel_ok, 0, 4'h0, 18'h00030, 0, 0);
    i_sleep_req <= 1'b0;
    see(1, 36'h123456789, "drive back");
    m.beat(1, 0, sel_ok, 1, 4'hF, 18'h00030, 1, 36'h111111111);
    see(0, 0, "write release");
    m.beat(0, 0, sel_ok, 1, 4'hF, 18'h00030, 1, 36'h222222222);
    m.beat(0, 0, sel_off, 1, 4'hF, 18'h0, 0, 0);
    see(1, 36'h222222222, "held write data");
  endtask : t_hold

  task automatic t_select();
    logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
    for (int i = 0; i < 3; i++) begin
      m.beat(0, 0, sel_ok, 1, 4'hF, 18'h00010, 0, 0);
      m.beat(0, 0, bad[i], 1, 4'hF, 18'h00010, 0, 0);
      see(1, 36'h123456789, "selected read");
      m.beat(0, 1, sel_ok, 1, 4'hF, 18'h0, 0, 0);
      see(0, 0, "deselect");
    end
  endtask : t_select

  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    check(dq_out, 36'h0, "reset data");
    check({35'h0, dq_oe}, 36'h0, "reset drive");
    t_pingpong();
    t_burst(1'b0);
    t_burst(1'b1);
    t_hold();
    t_select();
    report_and_stop();
  end
endmodule : zero_turnaround_sync_sram_port_tb_top
`default_nettype wire

// >>> dv/zts_master_model.sv
// Purpose: Bus master model for the zero-turnaround SRAM port.
// Assumes: One beat call per clock; pins change just after the edge.
// Notes:   Write data rides on the call after its command.
`include "zts_consts.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////
module zts_master_model (
  // Clock
  input  wire logic                i_mclk,
  // Synchronous controls, select is {a_n, b, c_n}
  output var  logic                o_cycle_hold_n,
  output var  logic                o_advance_load_n,
  output var  logic [2:0]          o_select,
  output var  logic                o_write_n,
  output var  zts_pkg::zts_lanes_t o_lane_write_n,
  output var  zts_pkg::zts_addr_t  o_addr,
  // Write data
  output var  zts_pkg::zts_word_t  o_dq
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_cycle_hold_n   = 1'b0;
    o_advance_load_n = 1'b1;
    o_select         = 3'h6;
    o_write_n        = 1'b1;
    o_lane_write_n   = 4'hF;
    o_addr           = 18'h00000;
    o_dq             = 36'h000000000;
  end

  task automatic beat(input logic hold, input logic ld_n, input logic [2:0] sel, input logic wr_n,
                      input zts_pkg::zts_lanes_t ln, input zts_pkg::zts_addr_t ad,
                      input logic wd, input zts_pkg::zts_word_t d);
    @(posedge i_mclk);
    o_cycle_hold_n   <= hold;
    o_advance_load_n <= ld_n;
    o_select         <= sel;
    o_write_n        <= wr_n;
    o_lane_write_n   <= ln;
    o_addr           <= ad;
    // Idle data lines toggle so a stale word never passes for fresh data
    o_dq             <= wd ? d : ~o_dq;
  endtask : beat
endmodule : zts_master_model
`default_nettype wire

// >>> src/zts_burst_seq.sv
// Purpose: Low address bits of a burst beat from its seed and beat count.
// Assumes: Order select is a level that may change at any time.
// Notes:   Purely combinational, so the order select acts without a clock.
`include "zts_consts.svh"
`default_nettype none

module zts_burst_seq (
  // Burst state
  input  wire logic             [`ZTS_SEED_W-1:0] i_seed,
  input  wire logic             [`ZTS_SEED_W-1:0] i_beat,
  // Order select, high for interleaved
  input  wire logic                               i_interleave,
  // Beat address
  output logic                  [`ZTS_SEED_W-1:0] o_low_addr
);

  always_comb begin
    if (i_interleave) begin
      o_low_addr = i_seed ^ i_beat;
    end else begin
      o_low_addr = i_seed + i_beat;        // wraps modulo four
    end
  end

endmodule : zts_burst_seq

`default_nettype wire

// >>> src/zts_consts.svh
// Purpose: Named constants for the zero-turnaround synchronous SRAM port.
// Assumes: Included by bare name from every design file that needs a figure.
// Notes:   Widths and depth are fixed; the storage is built from flip-flops.
`ifndef ZTS_CONSTS_SVH
`define ZTS_CONSTS_SVH

`define ZTS_ADDR_W    18
`define ZTS_DEPTH     262144
`define ZTS_DATA_W    36
`define ZTS_LANES     4
`define ZTS_LANE_W    9
`define ZTS_SEED_W    2
`define ZTS_BEAT_ZERO 2'h0
`define ZTS_BEAT_STEP 2'h1
`define ZTS_WORD_ZERO 36'h0
`define ZTS_ADDR_ZERO 18'h0
`define ZTS_LANES_OFF 4'hF
`define ZTS_LANES_ALL 4'h0

`endif

// >>> src/zts_pkg.sv
// Purpose: Types shared by the SRAM port, its master model and the bench.
// Assumes: zts_consts.svh supplies the widths.
// Notes:   Operation kinds carry no explicit codes.
`include "zts_consts.svh"
`default_nettype none

package zts_pkg;

  typedef logic [`ZTS_DATA_W-1:0] zts_word_t;
  typedef logic [`ZTS_ADDR_W-1:0] zts_addr_t;
  typedef logic [`ZTS_LANES-1:0]  zts_lanes_t;
  typedef logic [`ZTS_SEED_W-1:0] zts_beat_t;

  typedef enum logic [1:0] {
    ZTS_OP_IDLE,
    ZTS_OP_READ,
    ZTS_OP_WRITE
  } zts_op_e;

endpackage : zts_pkg

`default_nettype wire

// >>> src/zts_sram_port.sv
// Purpose: Zero-turnaround synchronous single-port SRAM with four-beat bursts.
// Assumes: One clock; the bus master presents controls and write data itself.
// Notes:   Flow-through reads, late writes; output drive, sleep and order act
//          without the clock, so the data enable is the one gated output.
//
// Overview of operation
// - All synchronous inputs are captured on the rising clock edge.
// - Read or write data moves on the bus one cycle after its address.
// - Cycle hold high freezes every register and ignores synchronous inputs.
// - Any inactive select on a load starts nothing and ends the burst.
// - A deselect still completes the data transfer already pending.
// - The data bus is released one cycle after a deselect or write start.
// - A two-bit burst counter gives four beats from one supplied address.
// - Burst order input picks linear or interleaved address sequence.
// - Advance-load low loads a new address; high advances the burst counter.
// - Output drive, sleep and burst order act without clock sampling.
// - Output drive deasserted disables the data outputs at once.
// - Each byte lane has an active-low write enable; all low writes all.
// - Reads and writes alternate on consecutive cycles without idle cycles.
// - On a load, select a or c high, or select b low, deselects.
// - Write select on a load fixes read or write for the whole burst.
// - Low two load address bits seed the burst counter.
`include "zts_consts.svh"
`default_nettype none

module zts_sram_port (
  // Clock and reset
  input  wire logic                               i_mclk,
  input  wire logic                               i_rst,
  // Synchronous controls
  input  wire logic                               i_cycle_hold_n,
  input  wire logic                               i_advance_load_n,
  input  wire logic                               i_select_a_n,
  input  wire logic                               i_select_b,
  input  wire logic                               i_select_c_n,
  input  wire logic                               i_write_n,
  input  wire logic             [`ZTS_LANES-1:0]  i_lane_write_n,
  input  wire logic             [`ZTS_ADDR_W-1:0] i_addr,
  // Asynchronous controls
  input  wire logic                               i_out_drive_n,
  input  wire logic                               i_sleep_req,
  input  wire logic                               i_burst_order,
  // Data bus
  input  wire logic             [`ZTS_DATA_W-1:0] i_dq,
  output logic                  [`ZTS_DATA_W-1:0] o_dq,
  output logic                                    o_dq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state

  zts_pkg::zts_word_t  mem [`ZTS_DEPTH];

  zts_pkg::zts_op_e    burst_op;
  zts_pkg::zts_addr_t  base_addr;
  zts_pkg::zts_beat_t  seed;
  zts_pkg::zts_beat_t  beat;

  zts_pkg::zts_op_e    pend_op;
  zts_pkg::zts_addr_t  pend_addr;
  zts_pkg::zts_lanes_t pend_lanes_n;

  logic                drive;

  ////////////////////////////////////////////////////////////////////////////
  // Lane merge, shared by the array write and the read bypass

  function automatic zts_pkg::zts_word_t lane_merge(
    input zts_pkg::zts_word_t  old_word,
    input zts_pkg::zts_word_t  new_word,
    input zts_pkg::zts_lanes_t lanes_n
  );
    zts_pkg::zts_word_t result;
    result = old_word;
    for (int i = 0; i < `ZTS_LANES; i++) begin
      if (!lanes_n[i]) begin
        result[i*`ZTS_LANE_W +: `ZTS_LANE_W] = new_word[i*`ZTS_LANE_W +: `ZTS_LANE_W];
      end
    end
    return result;
  endfunction : lane_merge

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode

  logic                enabled;
  logic                selected;
  logic                load;
  logic                advance;

  // Sleep is level and unclocked, so it simply blocks the edge like a hold
  assign enabled  = !i_cycle_hold_n && !i_sleep_req;
  assign selected = !i_select_a_n && i_select_b && !i_select_c_n;
  assign load     = enabled && !i_advance_load_n;
  assign advance  = enabled && i_advance_load_n;

  zts_pkg::zts_beat_t  next_beat;
  zts_pkg::zts_beat_t  burst_low;

  assign next_beat = beat + `ZTS_BEAT_STEP;

  zts_burst_seq u_burst_seq (
    .i_seed       (seed),
    .i_beat       (next_beat),
    .i_interleave (i_burst_order),
    .o_low_addr   (burst_low)
  );

  zts_pkg::zts_op_e    next_op;
  zts_pkg::zts_addr_t  next_addr;

  always_comb begin
    next_op   = zts_pkg::ZTS_OP_IDLE;
    next_addr = pend_addr;
    if (load) begin
      if (selected) begin
        next_op   = i_write_n ? zts_pkg::ZTS_OP_READ : zts_pkg::ZTS_OP_WRITE;
        next_addr = i_addr;
      end
    end else if (advance) begin
      next_op   = burst_op;
      next_addr = {base_addr[`ZTS_ADDR_W-1:`ZTS_SEED_W], burst_low};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst state

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      burst_op  <= zts_pkg::ZTS_OP_IDLE;
      base_addr <= `ZTS_ADDR_ZERO;
      seed      <= `ZTS_BEAT_ZERO;
      beat      <= `ZTS_BEAT_ZERO;
    end else if (load) begin
      burst_op  <= next_op;
      base_addr <= i_addr;
      seed      <= i_addr[`ZTS_SEED_W-1:0];
      beat      <= `ZTS_BEAT_ZERO;
    end else if (advance && burst_op != zts_pkg::ZTS_OP_IDLE) begin
      beat      <= next_beat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending transfer, one cycle behind its address

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pend_op      <= zts_pkg::ZTS_OP_IDLE;
      pend_addr    <= `ZTS_ADDR_ZERO;
      pend_lanes_n <= `ZTS_LANES_OFF;
    end else if (enabled) begin
      pend_op      <= next_op;
      pend_addr    <= next_addr;
      pend_lanes_n <= i_lane_write_n;
    end
  end

  // Write data arrives with the edge after the address, whatever is issued now
  always_ff @(posedge i_mclk) begin
    if (enabled && pend_op == zts_pkg::ZTS_OP_WRITE) begin
      mem[pend_addr] <= lane_merge(mem[pend_addr], i_dq, pend_lanes_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path with bypass of the write that lands on this same edge

  zts_pkg::zts_word_t  read_word;

  always_comb begin
    read_word = mem[next_addr];
    if (pend_op == zts_pkg::ZTS_OP_WRITE && pend_addr == next_addr) begin
      read_word = lane_merge(read_word, i_dq, pend_lanes_n);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_dq <= `ZTS_WORD_ZERO;
    end else if (enabled && next_op == zts_pkg::ZTS_OP_READ) begin
      o_dq <= read_word;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      drive <= 1'b0;
    end else if (enabled) begin
      drive <= (next_op == zts_pkg::ZTS_OP_READ);
    end
  end

  // Unclocked gating: the enable must drop at once, not at the next edge
  assign o_dq_oe = drive && !i_out_drive_n && !i_sleep_req;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_read_next_cycle;
    @(posedge i_mclk) disable iff (i_rst)
    (load && selected && i_write_n) |=> drive && pend_op == zts_pkg::ZTS_OP_READ;
  endproperty
  a_read_next_cycle: assert property (p_read_next_cycle)
    else $error("read did not drive in the following cycle");

  property p_hold_freezes;
    @(posedge i_mclk) disable iff (i_rst)
    (i_cycle_hold_n ##1 !i_rst) |-> $stable(o_dq) && $stable(drive) && $stable(beat) && $stable(pend_addr);
  endproperty
  a_hold_freezes: assert property (p_hold_freezes)
    else $error("state changed while cycle hold was high");

  property p_deselect_ends;
    @(posedge i_mclk) disable iff (i_rst)
    (load && !selected) |=> burst_op == zts_pkg::ZTS_OP_IDLE && pend_op == zts_pkg::ZTS_OP_IDLE;
  endproperty
  a_deselect_ends: assert property (p_deselect_ends)
    else $error("deselect left an operation or burst running");

  property p_pending_write_done;
    @(posedge i_mclk) disable iff (i_rst)
    (enabled && pend_op == zts_pkg::ZTS_OP_WRITE && pend_lanes_n == `ZTS_LANES_ALL)
      |=> mem[$past(pend_addr)] == $past(i_dq);
  endproperty
  a_pending_write_done: assert property (p_pending_write_done)
    else $error("pending full-word write was not stored");

  property p_write_releases;
    @(posedge i_mclk) disable iff (i_rst)
    (load && (!selected || !i_write_n)) |=> !drive && !o_dq_oe;
  endproperty
  a_write_releases: assert property (p_write_releases)
    else $error("data bus not released after write start or deselect");

  property p_linear_step;
    @(posedge i_mclk) disable iff (i_rst)
    (advance && burst_op != zts_pkg::ZTS_OP_IDLE && !i_burst_order)
      |=> pend_addr[`ZTS_SEED_W-1:0] == $past(seed) + $past(beat) + `ZTS_BEAT_STEP;
  endproperty
  a_linear_step: assert property (p_linear_step)
    else $error("linear burst address out of sequence");

  property p_interleave_step;
    @(posedge i_mclk) disable iff (i_rst)
    (advance && burst_op != zts_pkg::ZTS_OP_IDLE && i_burst_order)
      |=> pend_addr[`ZTS_SEED_W-1:0] == ($past(seed) ^ ($past(beat) + `ZTS_BEAT_STEP));
  endproperty
  a_interleave_step: assert property (p_interleave_step)
    else $error("interleaved burst address out of sequence");

  property p_load_seeds;
    @(posedge i_mclk) disable iff (i_rst)
    (load && selected) |=> pend_addr == $past(i_addr) && beat == `ZTS_BEAT_ZERO
      && seed == pend_addr[`ZTS_SEED_W-1:0];
  endproperty
  a_load_seeds: assert property (p_load_seeds)
    else $error("load did not take the external address and seed");

  property p_burst_keeps_kind;
    @(posedge i_mclk) disable iff (i_rst)
    (advance && burst_op == zts_pkg::ZTS_OP_WRITE) |=> pend_op == zts_pkg::ZTS_OP_WRITE && !drive;
  endproperty
  a_burst_keeps_kind: assert property (p_burst_keeps_kind)
    else $error("burst beat changed operation kind");

  property p_back_to_back;
    @(posedge i_mclk) disable iff (i_rst)
    (enabled && pend_op == zts_pkg::ZTS_OP_WRITE && next_op == zts_pkg::ZTS_OP_READ)
      |=> drive && pend_op == zts_pkg::ZTS_OP_READ;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("read after write was delayed");

  property p_drive_gate;
    @(posedge i_mclk) disable iff (i_rst)
    (i_out_drive_n || i_sleep_req) |-> !o_dq_oe;
  endproperty
  a_drive_gate: assert property (p_drive_gate)
    else $error("data enable high while output drive was off");

  // Advances with no live burst must stay idle, or a stale burst would resume
  property p_advance_idle;
    @(posedge i_mclk) disable iff (i_rst)
    (advance && burst_op == zts_pkg::ZTS_OP_IDLE) |=> pend_op == zts_pkg::ZTS_OP_IDLE && !drive;
  endproperty
  a_advance_idle: assert property (p_advance_idle)
    else $error("advance without a burst started an operation");

  property p_load_write;
    @(posedge i_mclk) disable iff (i_rst)
    (load && selected && !i_write_n) |=> pend_op == zts_pkg::ZTS_OP_WRITE && burst_op == zts_pkg::ZTS_OP_WRITE;
  endproperty
  a_load_write: assert property (p_load_write)
    else $error("write load did not start a write burst");

  property p_read_burst_drives;
    @(posedge i_mclk) disable iff (i_rst)
    (advance && burst_op == zts_pkg::ZTS_OP_READ) |=> pend_op == zts_pkg::ZTS_OP_READ && drive;
  endproperty
  a_read_burst_drives: assert property (p_read_burst_drives)
    else $error("read burst beat did not drive the bus");

endmodule : zts_sram_port

`default_nettype wire
